// >>> sar_readout.sv
// sar conversion sequencer with serial readout and result fifo
`timescale 1ns/1ps
`include "sar_map.svh"

// ****************************************************************
// result fifo with registered output stage
// ****************************************************************
module sar_fifo #(
   parameter int unsigned WIDTH = `SAR_FIFO_WIDTH,
   parameter int unsigned DEPTH = `SAR_FIFO_DEPTH
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic in_valid_i,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic in_ready_o,
   output logic out_valid_o,
   output logic [WIDTH-1:0] out_data_o,
   input wire logic out_ready_i
);
   localparam int unsigned PW = $clog2(DEPTH);
   localparam int unsigned CW = $clog2(DEPTH + 1);

   // refuse depths that the pointer wrap cannot serve
   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
      $error("sar_fifo depth must be a power of two of at least 2");
   end

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [PW-1:0] wr_q;
   logic [PW-1:0] rd_q;
   logic [CW-1:0] cnt_q;
   logic push;
   logic pop;

   // push when room, pop into the output stage when it frees
   assign in_ready_o = (cnt_q < CW'(DEPTH));
   assign push = in_valid_i && in_ready_o;
   assign pop = (cnt_q != '0) && (!out_valid_o || out_ready_i);

   // storage array
   always_ff @(posedge clk_i) begin
      if (push) begin
         mem_q[wr_q] <= in_data_i;
      end
   end

   // pointers and fill count
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wr_q <= wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= rd_q + 1'b1;
         end
         cnt_q <= cnt_q + CW'(push) - CW'(pop);
      end
   end

   // output stage, stalls while the consumer holds ready low
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         out_valid_o <= 1'b0;
         out_data_o <= '0;
      end else if (pop) begin
         out_valid_o <= 1'b1;
         out_data_o <= mem_q[rd_q];
      end else if (out_ready_i) begin
         out_valid_o <= 1'b0;
      end
   end
endmodule : sar_fifo

// ****************************************************************
// conversion sequencer and serial readout
// ****************************************************************
module sar_readout #(
   parameter int unsigned POR_CYCLES = `SAR_POR_CYCLES,
   parameter int unsigned FIFO_DEPTH = `SAR_FIFO_DEPTH
) (
   input wire logic SYS_CLK_I,
   input wire logic RSTN_I,
   input wire logic SELECT_AND_POWER_DOWN_N_I,
   input wire logic SERIAL_BIT_CLOCK_I,
   input wire logic COMP_I,
   output logic SDATA_O,
   output logic SDATA_OE_O,
   output logic [`SAR_RES_BITS-1:0] DAC_TRIAL_O,
   output logic SAMPLE_O,
   output logic STATIC_O,
   output logic READY_O,
   output logic RES_VALID_O,
   output logic [`SAR_FIFO_WIDTH-1:0] RES_DATA_O,
   input wire logic RES_READY_I
);
   localparam int unsigned PCW = $clog2(POR_CYCLES + 1);

   if (POR_CYCLES < 1) begin : g_chk
      $error("sar_readout power-on count must be at least 1");
   end

   sar_pkg::sar_state_t state_q;
   sar_pkg::sar_state_t state_d;
   logic [2:0] meta_q;
   logic [2:0] sync_q;
   logic [2:0] prev_q;
   logic sel_s;
   logic comp_s;
   logic sel_fall;
   logic clk_fall;
   logic [PCW-1:0] por_cnt_q;
   logic por_done;
   logic [1:0] fall_cnt_q;
   logic [`SAR_RES_BITS-1:0] trial_q;
   logic [`SAR_RES_BITS-1:0] result_q;
   logic [3:0] bit_idx_q;
   logic [3:0] steps_q;
   logic done_q;
   logic decide;
   logic conversion_phase_start;
   logic abort_part;
   logic push_q;
   logic [`SAR_FIFO_WIDTH-1:0] push_data_q;
   logic fifo_in_ready;

   // next trial level: keep the decided bit, try the next one lower
   function automatic logic [`SAR_RES_BITS-1:0] next_trial(input logic [`SAR_RES_BITS-1:0] t,
                                                          input logic [3:0] idx, input logic c);
      logic [`SAR_RES_BITS-1:0] n;
      n = t;
      n[idx] = c;
      if (idx != `SAR_LSB_IDX) begin
         n[idx - 4'h1] = 1'b1;
      end
      return n;
   endfunction : next_trial

   // low power whenever no conversion owns the pins
   function automatic logic is_idle(input sar_pkg::sar_state_t s);
      return (s == sar_pkg::ST_STATIC) || (s == sar_pkg::ST_POR);
   endfunction : is_idle

   // ****************************************************************
   // pin synchronisers and edge finders
   // ****************************************************************
   // two flops per pin, then a third copy for edges
   always_ff @(posedge SYS_CLK_I) begin
      if (!RSTN_I) begin
         meta_q <= `SAR_SYNC_RST;
         sync_q <= `SAR_SYNC_RST;
         prev_q <= `SAR_SYNC_RST;
      end else begin
         meta_q <= {COMP_I, SERIAL_BIT_CLOCK_I, SELECT_AND_POWER_DOWN_N_I};
         sync_q <= meta_q;
         prev_q <= sync_q;
      end
   end

   assign sel_s = sync_q[0];
   assign comp_s = sync_q[2];
   assign sel_fall = prev_q[0] && !sync_q[0];
   assign clk_fall = prev_q[1] && !sync_q[1];

   // ****************************************************************
   // power-on reset
   // ****************************************************************
   // hold off conversions until the power-on time has run
   always_ff @(posedge SYS_CLK_I) begin
      if (!RSTN_I) begin
         por_cnt_q <= '0;
      end else if (!por_done) begin
         por_cnt_q <= por_cnt_q + 1'b1;
      end
   end

   assign por_done = (por_cnt_q == PCW'(POR_CYCLES - 1));

   // ****************************************************************
   // sequencer
   // ****************************************************************
   // select decides static or dynamic, whatever the clock did; a full fifo also holds off the start
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         sar_pkg::ST_POR: begin
            if (por_done) begin
               state_d = sar_pkg::ST_STATIC;
            end
         end
         sar_pkg::ST_STATIC: begin
            if (sel_fall && fifo_in_ready) begin
               state_d = sar_pkg::ST_ACQ;
            end
         end
         sar_pkg::ST_ACQ: begin
            if (sel_s) begin
               state_d = sar_pkg::ST_STATIC;
            end else if (clk_fall && fall_cnt_q == `SAR_ACQ_FALLS - 2'h1) begin
               state_d = sar_pkg::ST_CONVERSION_PHASE;
            end
         end
         sar_pkg::ST_CONVERSION_PHASE: begin
            if (sel_s) begin
               state_d = sar_pkg::ST_STATIC;
            end
         end
      endcase
   end

   always_ff @(posedge SYS_CLK_I) begin
      if (!RSTN_I) begin
         state_q <= sar_pkg::ST_POR;
      end else begin
         state_q <= state_d;
      end
   end

   assign conversion_phase_start = (state_q == sar_pkg::ST_ACQ) && (state_d == sar_pkg::ST_CONVERSION_PHASE);
   assign decide = (state_q == sar_pkg::ST_CONVERSION_PHASE) && !sel_s && clk_fall && !done_q;
   assign abort_part = (state_q == sar_pkg::ST_CONVERSION_PHASE) && sel_s && !done_q && (steps_q != 4'h0);

   // falling clock edges seen during acquisition
   always_ff @(posedge SYS_CLK_I) begin
      if (!RSTN_I) begin
         fall_cnt_q <= 2'h0;
      end else if (state_q != sar_pkg::ST_ACQ) begin
         fall_cnt_q <= 2'h0;
      end else if (clk_fall) begin
         fall_cnt_q <= fall_cnt_q + 2'h1;
      end
   end

   // ****************************************************************
   // successive approximation
   // ****************************************************************
   // one decision per falling clock edge, msb first
   always_ff @(posedge SYS_CLK_I) begin
      if (!RSTN_I) begin
         trial_q <= '0;
         result_q <= '0;
         bit_idx_q <= `SAR_MSB_IDX;
         steps_q <= 4'h0;
         done_q <= 1'b0;
      end else if (conversion_phase_start) begin
         trial_q <= `SAR_TRIAL_MSB;
         result_q <= '0;
         bit_idx_q <= `SAR_MSB_IDX;
         steps_q <= 4'h0;
         done_q <= 1'b0;
      end else if (decide) begin
         result_q[bit_idx_q] <= comp_s;
         trial_q <= next_trial(trial_q, bit_idx_q, comp_s);
         steps_q <= steps_q + 4'h1;
         if (bit_idx_q == `SAR_LSB_IDX) begin
            done_q <= 1'b1;
         end else begin
            bit_idx_q <= bit_idx_q - 4'h1;
         end
      end
   end

   // ****************************************************************
   // serial data pin
   // ****************************************************************
   // enable with the null bit, then each decision as it is made
   always_ff @(posedge SYS_CLK_I) begin
      if (!RSTN_I) begin
         SDATA_O <= 1'b0;
         SDATA_OE_O <= 1'b0;
      end else if (is_idle(state_d)) begin
         SDATA_O <= 1'b0;
         SDATA_OE_O <= 1'b0;
      end else if (conversion_phase_start) begin
         SDATA_O <= 1'b0;
         SDATA_OE_O <= 1'b1;
      end else if (decide) begin
         SDATA_O <= comp_s;
      end else if ((state_q == sar_pkg::ST_CONVERSION_PHASE) && clk_fall) begin
         SDATA_O <= 1'b0; // trailing zeros after the lsb
      end
   end

   // ****************************************************************
   // status pins and trial level
   // ****************************************************************
   always_ff @(posedge SYS_CLK_I) begin
      if (!RSTN_I) begin
         SAMPLE_O <= 1'b0;
         STATIC_O <= 1'b1;
         READY_O <= 1'b0;
         DAC_TRIAL_O <= '0;
      end else begin
         SAMPLE_O <= (state_d == sar_pkg::ST_ACQ);
         STATIC_O <= is_idle(state_d);
         READY_O <= (state_d != sar_pkg::ST_POR);
         DAC_TRIAL_O <= trial_q;
      end
   end

   // ****************************************************************
   // result hand-off
   // ****************************************************************
   // full result on the last decision, partial one on deselect after at least one decision
   always_ff @(posedge SYS_CLK_I) begin
      if (!RSTN_I) begin
         push_q <= 1'b0;
         push_data_q <= '0;
      end else if (decide && bit_idx_q == `SAR_LSB_IDX) begin
         push_q <= 1'b1;
         push_data_q <= {`SAR_FULL_STEPS, result_q[`SAR_RES_BITS-1:1], comp_s};
      end else if (abort_part) begin
         push_q <= 1'b1;
         push_data_q <= {steps_q, result_q};
      end else begin
         push_q <= 1'b0;
      end
   end

   // a full fifo holds off the next conversion start
   sar_fifo #(
      .WIDTH(`SAR_FIFO_WIDTH),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk_i(SYS_CLK_I),
      .rst_n_i(RSTN_I),
      .in_valid_i(push_q),
      .in_data_i(push_data_q),
      .in_ready_o(fifo_in_ready),
      .out_valid_o(RES_VALID_O),
      .out_data_o(RES_DATA_O),
      .out_ready_i(RES_READY_I)
   );

   // ****************************************************************
   // assertions
   // ****************************************************************
   default clocking cb @(posedge SYS_CLK_I);
   endclocking
   default disable iff (!RSTN_I);

   AST_POR_HOLD: assert property (
      (state_q == sar_pkg::ST_POR && !por_done) |=> (state_q == sar_pkg::ST_POR) && !SDATA_OE_O && !READY_O)
      else $error("left power-on reset early");
   AST_START: assert property (
      (state_q == sar_pkg::ST_STATIC && sel_fall && fifo_in_ready) |=> (state_q == sar_pkg::ST_ACQ) && !SDATA_OE_O)
      else $error("select fall did not start acquisition");
   AST_NULL_BIT: assert property (
      (state_q == sar_pkg::ST_ACQ && !sel_s && clk_fall && fall_cnt_q == 2'h1)
      |=> SDATA_OE_O && !SDATA_O && (state_q == sar_pkg::ST_CONVERSION_PHASE) && (trial_q == 12'h0800))
      else $error("null bit or msb trial missing at conversion start");
   AST_ACQ_QUIET: assert property (
      (state_q == sar_pkg::ST_ACQ) |-> !SDATA_OE_O)
      else $error("output enabled before second clock pulse");
   AST_DECIDE: assert property (
      decide |=> (SDATA_O == $past(comp_s)) && (result_q[$past(bit_idx_q)] == $past(comp_s)))
      else $error("decision not shown on the data pin");
   AST_TWELVE: assert property (
      $rose(done_q) |-> (steps_q == 4'hC) && (bit_idx_q == 4'h0) && push_q)
      else $error("conversion did not take twelve steps");
   AST_ABORT: assert property (
      (sel_s && state_q != sar_pkg::ST_POR) |=> !SDATA_OE_O && STATIC_O && (state_q == sar_pkg::ST_STATIC))
      else $error("deselect did not release the pin");
   AST_SHORT: assert property (
      abort_part |=> push_q && (push_data_q[15:12] == $past(steps_q)) && (push_data_q[11:0] == $past(result_q)))
      else $error("partial result not delivered");

   COV_FULL: cover property (decide && bit_idx_q == 4'h0);
   COV_SHORT: cover property (abort_part);
   COV_STALL: cover property (state_q == sar_pkg::ST_STATIC && sel_fall && !fifo_in_ready);
   COV_READ: cover property (RES_VALID_O && RES_READY_I);
endmodule : sar_readout

// >>> sar_map.svh
// constants of the sar converter sequencer and its serial readout
`ifndef SAR_MAP_SVH
`define SAR_MAP_SVH
// ****************************************************************
// timing
// ****************************************************************
`define SAR_CLK_PERIOD_NS 5
`define SAR_POR_TIME_NS 2500000
`define SAR_POR_CYCLES ((`SAR_POR_TIME_NS + `SAR_CLK_PERIOD_NS - 1) / `SAR_CLK_PERIOD_NS)
`define SAR_ACQ_FALLS 2'h2
// ****************************************************************
// result layout and reset values
// ****************************************************************
`define SAR_RES_BITS 12
`define SAR_TRIAL_MSB 12'h800
`define SAR_LSB_IDX 4'h0
`define SAR_MSB_IDX 4'hB
`define SAR_FULL_STEPS 4'hC
`define SAR_FLD_CNT_LSB 12
`define SAR_FIFO_WIDTH 16
`define SAR_FIFO_DEPTH 32
`define SAR_SYNC_RST 3'h1 // select high, serial clock low: the idle levels, so no false edge after reset
`endif

// >>> sar_pkg.sv
// types of the sar converter sequencer
package sar_pkg;
   // ****************************************************************
   // sequencer states
   // ****************************************************************
   typedef enum logic [3:0] {
      ST_POR = 4'h1,
      ST_STATIC = 4'h2,
      ST_ACQ = 4'h4,
      ST_CONVERSION_PHASE = 4'h8
   } sar_state_t;
endpackage : sar_pkg

// >>> sar_host_model.sv
// host side model: serial master driving select and serial clock
`timescale 1ns/1ps
module sar_host_model (
   input wire logic clk_i,
   input wire logic sdata_i,
   output logic sel_n_o,
   output logic sclk_o
);
   // half of a 160 ns serial clock in 5 ns system cycles
   localparam int HALF = 16;
   logic [15:0] cap_q;
   // idle levels: select high, serial clock still and low
   initial begin
      sel_n_o = 1'b1;
      sclk_o = 1'b0;
      cap_q = 16'h0000;
   end
   task automatic wait_cyc(input int n);
      repeat (n) @(negedge clk_i);
   endtask : wait_cyc
   // select low, then keep the clock still for half a period
   task automatic sel_fall();
      @(negedge clk_i);
      sel_n_o = 1'b0;
      wait_cyc(HALF);
   endtask : sel_fall
   // clock pulses; data taken on rising edges from the third pulse on
   task automatic clocks(input int n);
      for (int i = 1; i <= n; i++) begin
         sclk_o = 1'b1;
         if (i > 2) cap_q = {cap_q[14:0], sdata_i};
         wait_cyc(HALF);
         sclk_o = 1'b0;
         wait_cyc(HALF);
      end
   endtask : clocks
   task automatic sel_rise();
      @(negedge clk_i);
      sel_n_o = 1'b1;
   endtask : sel_rise
   // one framed transfer, then a pause so data is hi-z and acquisition fits
   task automatic frame(input int n);
      sel_fall();
      clocks(n);
      sel_rise();
      wait_cyc(HALF);
   endtask : frame
endmodule : sar_host_model

// >>> sar_adc_serial_readout_tb.sv
// self-checking testbench of the sar converter sequencer
`timescale 1ns/1ps
module sar_adc_serial_readout_tb;
   localparam int unsigned POR_CYC = 20;
   localparam int unsigned FIFO_D = 32;
   logic clk, rst_n, sel_n, sclk, comp, sdata, sdata_oe, sample, stat, rdy;
   logic res_valid, res_ready, wire_lvl;
   logic last_q = 1'b0;
   logic [11:0] trial;
   logic [11:0] vin;
   logic [15:0] res_data;
   int fails = 0;
   int checks_done = 0;
   sar_readout #(.POR_CYCLES(POR_CYC), .FIFO_DEPTH(FIFO_D)) sar_readout_i (
      .SYS_CLK_I(clk), .RSTN_I(rst_n), .SELECT_AND_POWER_DOWN_N_I(sel_n),
      .SERIAL_BIT_CLOCK_I(sclk), .COMP_I(comp), .SDATA_O(sdata), .SDATA_OE_O(sdata_oe),
      .DAC_TRIAL_O(trial), .SAMPLE_O(sample), .STATIC_O(stat), .READY_O(rdy),
      .RES_VALID_O(res_valid), .RES_DATA_O(res_data), .RES_READY_I(res_ready));
   sar_host_model sar_host_model_i (.clk_i(clk), .sdata_i(wire_lvl), .sel_n_o(sel_n), .sclk_o(sclk));
   // comparator of an ideal input against the trial level
   assign comp = (vin >= trial);
   // released data line shows the inverse of its last driven value
   always @(posedge clk) if (sdata_oe) last_q <= sdata;
   assign wire_lvl = sdata_oe ? sdata : ~last_q;
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // ****************************************************************
   // helpers
   // ****************************************************************
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic give_verdict();
      $display("checks %0d fails %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : give_verdict
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask : cyc
   // compare the standing word at a falling edge, then take it with one ready pulse
   task automatic take_word(input logic [15:0] exp);
      int n;
      n = 0;
      @(negedge clk);
      while (res_valid !== 1'b1 && n < 40) begin
         n++;
         @(negedge clk);
      end
      chk(16'(res_valid), 16'h0001);
      chk(res_data, exp);
      res_ready = 1'b1;
      @(negedge clk);
      res_ready = 1'b0;
   endtask : take_word
   task automatic no_word();
      cyc(8);
      chk(16'(res_valid), 16'h0000);
   endtask : no_word
   // ****************************************************************
   // scenarios
   // ****************************************************************
   task automatic t_por();
      sar_host_model_i.sel_fall();
      chk(16'({rdy, stat, sdata_oe}), 16'h0002);
      cyc(40);
      chk(16'(rdy), 16'h0001);
      sar_host_model_i.clocks(3);
      cyc(6);
      chk(16'(sdata_oe), 16'h0000);
      sar_host_model_i.sel_rise();
      sar_host_model_i.wait_cyc(16);
      no_word();
      vin = 12'h123;
      sar_host_model_i.frame(16);
      take_word({4'hC, vin});
   endtask : t_por
   task automatic t_full();
      logic [11:0] tbl [4];
      tbl = '{12'h000, 12'hFFF, 12'hA5C, 12'h801};
      foreach (tbl[i]) begin
         vin = tbl[i];
         sar_host_model_i.frame(16);
         chk(16'(sar_host_model_i.cap_q[13:0]), {3'b000, vin, 1'b0});
         take_word({4'hC, vin});
      end
   endtask : t_full
   task automatic t_short();
      int ns [2];
      ns = '{3, 13};
      vin = 12'hB6D;
      sar_host_model_i.sel_fall();
      chk(16'({sample, stat}), 16'h0002);
      sar_host_model_i.clocks(1);
      cyc(6);
      chk(16'({sample, sdata_oe}), 16'h0002);
      sar_host_model_i.clocks(1);
      cyc(6);
      chk(16'({sample, sdata_oe, sdata}), 16'h0002);
      chk(16'(trial), 16'h0800);
      sar_host_model_i.clocks(6);
      sar_host_model_i.sel_rise();
      cyc(5);
      chk(16'({sdata_oe, stat}), 16'h0001);
      take_word({4'h6, vin & 12'hFC0});
      foreach (ns[i]) begin
         sar_host_model_i.frame(ns[i]);
         take_word({4'(ns[i] - 2), vin & (12'hFFF << (14 - ns[i]))});
      end
      sar_host_model_i.frame(2);
      no_word();
   endtask : t_short
   task automatic t_fifo();
      for (int i = 0; i < 33; i++) begin
         vin = 12'(i * 97);
         sar_host_model_i.frame(3);
      end
      sar_host_model_i.sel_fall();
      sar_host_model_i.clocks(3);
      cyc(6);
      chk(16'(sdata_oe), 16'h0000);
      sar_host_model_i.sel_rise();
      sar_host_model_i.wait_cyc(16);
      for (int i = 0; i < 33; i++) begin
         cyc(3);
         take_word({4'h1, 12'(i * 97) & 12'h800});
      end
      no_word();
   endtask : t_fifo
   // ****************************************************************
   // main sequence and watchdog
   // ****************************************************************
   initial begin
      rst_n = 1'b0;
      res_ready = 1'b0;
      vin = 12'h000;
      cyc(4);
      rst_n = 1'b1;
      t_por();
      t_full();
      t_short();
      t_fifo();
      give_verdict();
   end
   initial begin
      repeat (30000) @(posedge clk);
      fails++;
      give_verdict();
   end
endmodule : sar_adc_serial_readout_tb
